// ### common/asi_pkg.sv
/*
  Constants, register map and carrier types for the async serial interface.
  Assumes a byte-addressed plain register port and one system clock.
*/
package asi_pkg;

  // ==========================================================
  // register map (byte offsets, one aligned word each)
  localparam logic [7:0] ASI_RATE_OFS = 8'h00;
  localparam logic [7:0] ASI_CTRL_OFS = 8'h04;
  localparam logic [7:0] ASI_STAT_OFS = 8'h08;
  localparam logic [7:0] ASI_DATA_OFS = 8'h0C;
  localparam logic [7:0] ASI_PIN_OFS  = 8'h10;

  // ==========================================================
  // line control fields
  localparam int unsigned ASI_C_RE   = 0;
  localparam int unsigned ASI_C_TE   = 1;
  localparam int unsigned ASI_C_LEN  = 2;
  localparam int unsigned ASI_C_PE   = 3;
  localparam int unsigned ASI_C_PT   = 4;
  localparam int unsigned ASI_C_IDLE_IRQ_ENABLE = 5;
  localparam int unsigned ASI_C_RIE  = 6;
  localparam int unsigned ASI_C_TX_COMPLETE_IRQ_ENABLE = 7;
  localparam int unsigned ASI_C_TIE  = 8;
  localparam int unsigned ASI_CTRL_W = 9;

  // ==========================================================
  // line status fields
  localparam int unsigned ASI_S_PF   = 0;
  localparam int unsigned ASI_S_FE   = 1;
  localparam int unsigned ASI_S_OVR  = 2;
  localparam int unsigned ASI_S_IDLE = 3;
  localparam int unsigned ASI_S_RX_BUFFER_FULL_FLAG = 4;
  localparam int unsigned ASI_S_TC   = 5;
  localparam int unsigned ASI_S_TX_BUFFER_EMPTY_FLAG = 6;
  localparam int unsigned ASI_STAT_W = 7;
  localparam logic [6:0]  ASI_RX_FLAGS = 7'h1F;

  // ==========================================================
  // pin assignment fields
  localparam int unsigned ASI_P_ASSIGN = 0;
  localparam int unsigned ASI_P_GVAL   = 1;
  localparam int unsigned ASI_P_GDIR   = 2;
  localparam int unsigned ASI_P_GIN    = 3;

  // ==========================================================
  // reset values
  localparam logic [12:0] ASI_RATE_RST = 13'h0000;
  localparam logic [8:0]  ASI_CTRL_RST = 9'h000;
  localparam logic [6:0]  ASI_STAT_RST = 7'h60;
  localparam logic [2:0]  ASI_PIN_RST  = 3'h0;

  // ==========================================================
  // timing
  localparam logic [3:0] ASI_PHASE_LAST = 4'hF;
  localparam logic [3:0] ASI_SAMPLE_PH  = 4'h8;
  localparam logic [7:0] ASI_IDLE10     = 8'hA0;
  localparam logic [7:0] ASI_IDLE11     = 8'hB0;

  typedef enum logic [0:0] {ASI_RX_IDLE, ASI_RX_BITS} asi_rx_e;
  typedef enum logic [1:0] {ASI_TX_IDLE, ASI_TX_PRE, ASI_TX_FRAME} asi_tx_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } asi_bus_s;

endpackage

// ### logic/asi_serial_if.sv
/*
  Async NRZ serial interface: rate generator, receiver, transmitter,
  status with read-then-access clearing, request gating, tx pin sharing.
  Assumes the register master keeps the plain-port strobe protocol and
  that rxd_i and txd_i arrive asynchronously from pins.
*/
// Added by the designer: the placing of the registers and the plain strobed port.
// Function
// RQ1 - bit rate is system clock over 32 times 13-bit divisor
// RQ2 - divisor 1 to 8191 valid; zero stops the rate generator
// RQ3 - sampling tick runs at sixteen times the bit rate
// RQ4 - receiver realigns sampling phase on every line transition
// RQ5 - start needs falling edge after three high samples
// RQ6 - length bit picks 10 or 11 bit frames with start and stop
// RQ7 - data sent and received LSB first between start and stop
// RQ8 - idle frame is all ones; break frame all zeros, no stop
// RQ9 - parity type 0 even, 1 odd, for both directions
// RQ10 - parity enable puts parity in top data position
// RQ11 - parity mismatch on receive sets parity error flag
// RQ12 - length/parity pick 8, 7+p, 9 or 8+p data bits
// RQ13 - one data address: read rx buffer, write tx buffer
// RQ14 - status read then data access clears the flags
// RQ15 - data read clears rx flags only, not tx flags
// RQ16 - flags set after the status read survive the access
// RQ17 - status read arms every flag set in either byte
// RQ18 - four enables gate tx empty, tx done, rx full, idle
// RQ19 - flags behave the same regardless of enables
// RQ20 - tx pin owned by serial or gpio; rx pin dedicated
// RQ21 - software sets divisor before enabling tx or rx
// RQ22 - software disables tx and rx before changing controls
// RQ23 - tx empty flag sets when buffer moves to shifter
// RQ24 - stop bit moves frame to rx buffer and sets rx full
`timescale 1ns/10ps

module asi_serial_if #(
  parameter int unsigned DIV_W = 13
) (
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  input  wire asi_pkg::asi_bus_s bus_i,
  output logic [31:0]           rd_data_o,
  input  wire logic             rxd_i,
  input  wire logic             txd_i,
  output logic                  txd_o,
  output logic                  txd_oe_o,
  output logic [3:0]            irq_req_o
);
  import asi_pkg::*;

  if (DIV_W < 1 || DIV_W > 16) begin : g_chk
    $error("DIV_W out of range");
  end

  // ==========================================================
  // registers and decode
  logic [DIV_W-1:0]      divisor;
  logic [ASI_CTRL_W-1:0] ctrl;
  logic [2:0]            pin_cfg;
  logic [ASI_STAT_W-1:0] flags;
  logic [ASI_STAT_W-1:0] arm;
  logic [ASI_STAT_W-1:0] set_f;
  logic [ASI_STAT_W-1:0] clr_f;
  logic [8:0]            rbuf;
  logic [8:0]            tbuf;
  logic                  data_rd;
  logic                  data_wr;
  logic                  stat_rd;
  logic                  rx_meta;
  logic                  rx_s;
  logic                  txin_meta;
  logic                  txin_s;

  always_comb begin
    data_rd = bus_i.rd && (bus_i.addr == ASI_DATA_OFS);
    data_wr = bus_i.wr && (bus_i.addr == ASI_DATA_OFS);
    stat_rd = bus_i.rd && (bus_i.addr == ASI_STAT_OFS);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      divisor <= DIV_W'(ASI_RATE_RST);
      ctrl    <= ASI_CTRL_RST;
      pin_cfg <= ASI_PIN_RST;
    end else if (bus_i.wr) begin
      if (bus_i.addr == ASI_RATE_OFS) begin
        divisor <= bus_i.wdata[DIV_W-1:0];
      end else if (bus_i.addr == ASI_CTRL_OFS) begin
        ctrl <= bus_i.wdata[ASI_CTRL_W-1:0];
      end else if (bus_i.addr == ASI_PIN_OFS) begin
        pin_cfg <= bus_i.wdata[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tbuf <= 9'h000;
    end else if (data_wr) begin
      tbuf <= bus_i.wdata[8:0]; // RQ13
    end
  end

  // whole status word is one access, so either byte arms all flags
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arm <= '0;
    end else if (stat_rd) begin
      arm <= flags; // RQ17
    end else if (data_rd || data_wr) begin
      arm <= '0;
    end
  end

  always_comb begin
    clr_f = '0;
    if (data_wr) begin
      clr_f = arm; // RQ14
    end else if (data_rd) begin
      clr_f = arm & ASI_RX_FLAGS; // RQ15
    end
  end

  // hardware set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags <= ASI_STAT_RST;
    end else begin
      flags <= (flags & ~clr_f) | set_f; // RQ16 RQ19
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_o <= 32'h0000_0000;
    end else if (bus_i.rd) begin
      if (bus_i.addr == ASI_RATE_OFS) begin
        rd_data_o <= 32'(divisor);
      end else if (bus_i.addr == ASI_CTRL_OFS) begin
        rd_data_o <= 32'(ctrl);
      end else if (bus_i.addr == ASI_STAT_OFS) begin
        rd_data_o <= 32'(flags);
      end else if (bus_i.addr == ASI_DATA_OFS) begin
        rd_data_o <= 32'(rbuf); // RQ13
      end else if (bus_i.addr == ASI_PIN_OFS) begin
        rd_data_o <= 32'({txin_s, pin_cfg});
      end else begin
        rd_data_o <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // rate generator: tick every 2*divisor clocks gives 16x rate
  logic [DIV_W:0] bcnt;
  logic           tick;

  always_comb begin
    tick = (divisor != '0) &&
           (bcnt == (DIV_W+1)'({divisor, 1'b0} - 1'b1)); // RQ1 RQ3
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bcnt <= '0;
    end else if (divisor == '0 || tick) begin
      bcnt <= '0; // RQ2
    end else begin
      bcnt <= bcnt + 1'b1;
    end
  end

  // ==========================================================
  // pin synchronisers

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_meta   <= 1'b1;
      rx_s      <= 1'b1;
      txin_meta <= 1'b1;
      txin_s    <= 1'b1;
    end else begin
      rx_meta   <= rxd_i;
      rx_s      <= rx_meta;
      txin_meta <= txd_i;
      txin_s    <= txin_meta;
    end
  end

  // ==========================================================
  // receiver
  asi_rx_e    rx_st;
  logic [2:0] hist;
  logic       rx_prev;
  logic [3:0] rph;
  logic [3:0] rbit;
  logic [8:0] rsh;
  logic [3:0] nd;
  logic       rx_start;
  logic       rx_done;
  logic       rx_stop;
  logic       rx_sample;
  logic [7:0] icnt;
  logic [7:0] ilim;
  logic       idle_hit;

  always_comb begin
    nd        = ctrl[ASI_C_LEN] ? 4'h9 : 4'h8; // RQ6 RQ12
    ilim      = ctrl[ASI_C_LEN] ? ASI_IDLE11 : ASI_IDLE10;
    rx_start  = tick && (rx_st == ASI_RX_IDLE) && ctrl[ASI_C_RE] &&
                (hist == 3'b111) && !rx_s; // RQ5
    rx_sample = tick && (rx_st == ASI_RX_BITS) && (rph == ASI_SAMPLE_PH);
    rx_done   = rx_sample && (rbit == nd + 4'h1);
    rx_stop   = rx_s;
    idle_hit  = tick && ctrl[ASI_C_RE] && rx_s &&
                (icnt == ilim - 8'h01);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hist <= 3'b000;
    end else if (tick) begin
      hist <= {hist[1:0], rx_s};
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_st   <= ASI_RX_IDLE;
      rx_prev <= 1'b1;
      rph     <= 4'h0;
      rbit    <= 4'h0;
      rsh     <= 9'h000;
    end else if (rx_start) begin
      rx_st   <= ASI_RX_BITS;
      rx_prev <= 1'b0;
      rph     <= 4'h1;
      rbit    <= 4'h0;
      rsh     <= 9'h000;
    end else if (tick && rx_st == ASI_RX_BITS) begin
      rx_prev <= rx_s;
      if (rx_s != rx_prev) begin
        rph <= 4'h1; // RQ4
      end else begin
        rph <= rph + 4'h1;
      end
      if (rx_sample) begin
        rbit <= rbit + 4'h1;
        if (rbit == 4'h0 && rx_s) begin
          rx_st <= ASI_RX_IDLE;
        end else if (rbit != 4'h0 && rbit <= nd) begin
          rsh[rbit-4'h1] <= rx_s; // RQ7
        end
        if (rx_done) begin
          rx_st <= ASI_RX_IDLE;
        end
      end
    end
  end

  // short idle detection: contiguous ones equal to a frame length
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      icnt <= 8'h00;
    end else if (!rx_s || !ctrl[ASI_C_RE]) begin
      icnt <= 8'h00;
    end else if (tick && icnt != ilim) begin
      icnt <= icnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rbuf <= 9'h000;
    end else if (rx_done && !flags[ASI_S_RX_BUFFER_FULL_FLAG]) begin
      rbuf <= rsh; // RQ24
    end
  end

  // ==========================================================
  // transmitter
  asi_tx_e     tx_st;
  logic [10:0] tsh;
  logic [3:0]  tph;
  logic [3:0]  tbits;
  logic        te_prev;
  logic        pre_req;
  logic        tx_load;
  logic        tx_pre;
  logic        tx_end;
  logic        tx_busy;
  logic [8:0]  tword;
  logic [3:0]  flen;

  always_comb begin
    flen  = ctrl[ASI_C_LEN] ? 4'hB : 4'hA;
    tword = tbuf;
    if (!ctrl[ASI_C_LEN]) begin
      tword[8] = 1'b1; // RQ6
    end
    if (ctrl[ASI_C_PE]) begin
      if (ctrl[ASI_C_LEN]) begin
        tword[8] = ^tbuf[7:0] ^ ctrl[ASI_C_PT]; // RQ9 RQ10
      end else begin
        tword[7] = ^tbuf[6:0] ^ ctrl[ASI_C_PT]; // RQ9 RQ10
      end
    end
    tx_busy = (tx_st != ASI_TX_IDLE);
    tx_pre  = !tx_busy && pre_req;
    tx_load = !tx_busy && !pre_req && ctrl[ASI_C_TE] &&
              !flags[ASI_S_TX_BUFFER_EMPTY_FLAG];
    tx_end  = tx_busy && tick && (tph == ASI_PHASE_LAST) &&
              (tbits == flen - 4'h1);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      te_prev <= 1'b0;
      pre_req <= 1'b0;
    end else begin
      te_prev <= ctrl[ASI_C_TE];
      if (ctrl[ASI_C_TE] && !te_prev) begin
        pre_req <= 1'b1;
      end else if (tx_pre) begin
        pre_req <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_st <= ASI_TX_IDLE;
      tsh   <= 11'h7FF;
      tph   <= 4'h0;
      tbits <= 4'h0;
    end else begin
      case (tx_st)
        ASI_TX_IDLE: begin
          tph   <= 4'h0;
          tbits <= 4'h0;
          if (tx_pre) begin
            tx_st <= ASI_TX_PRE;
            tsh   <= 11'h7FF; // RQ8
          end else if (tx_load) begin
            tx_st <= ASI_TX_FRAME;
            tsh   <= {1'b1, tword, 1'b0}; // RQ6 RQ7
          end
        end
        default: begin
          if (tick) begin
            tph <= tph + 4'h1;
            if (tph == ASI_PHASE_LAST) begin
              tsh   <= {1'b1, tsh[10:1]};
              tbits <= tbits + 4'h1;
            end
          end
          if (tx_end) begin
            tx_st <= ASI_TX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // flag events
  logic par_bad;

  always_comb begin
    par_bad = (^rsh) != ctrl[ASI_C_PT];
    set_f = '0;
    set_f[ASI_S_TX_BUFFER_EMPTY_FLAG] = tx_load; // RQ23
    set_f[ASI_S_TC]   = tx_end && flags[ASI_S_TX_BUFFER_EMPTY_FLAG] && !pre_req;
    set_f[ASI_S_IDLE] = idle_hit;
    if (rx_done) begin
      if (flags[ASI_S_RX_BUFFER_FULL_FLAG]) begin
        set_f[ASI_S_OVR] = 1'b1;
      end else begin
        set_f[ASI_S_RX_BUFFER_FULL_FLAG] = 1'b1; // RQ24
        set_f[ASI_S_PF]   = ctrl[ASI_C_PE] && par_bad; // RQ11
        set_f[ASI_S_FE]   = !rx_stop; // RQ8
      end
    end
  end

  // ==========================================================
  // pin ownership and requests, registered
  logic own_tx;

  always_comb begin
    own_tx = pin_cfg[ASI_P_ASSIGN] && (ctrl[ASI_C_TE] || tx_busy);
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      txd_o    <= 1'b0;
      txd_oe_o <= 1'b0;
    end else if (own_tx) begin
      txd_o    <= tx_busy ? tsh[0] : 1'b1; // RQ20
      txd_oe_o <= 1'b1;
    end else begin
      txd_o    <= pin_cfg[ASI_P_GVAL]; // RQ20
      txd_oe_o <= pin_cfg[ASI_P_GDIR];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_req_o <= 4'h0;
    end else begin
      irq_req_o <= {flags[ASI_S_TX_BUFFER_EMPTY_FLAG] & ctrl[ASI_C_TIE],
                    flags[ASI_S_TC]   & ctrl[ASI_C_TX_COMPLETE_IRQ_ENABLE],
                    flags[ASI_S_RX_BUFFER_FULL_FLAG] & ctrl[ASI_C_RIE],
                    flags[ASI_S_IDLE] & ctrl[ASI_C_IDLE_IRQ_ENABLE]}; // RQ18
    end
  end

  // ==========================================================
  // assertions
  logic [DIV_W+1:0] gap;
  logic             gap_ok;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gap    <= '0;
      gap_ok <= 1'b0;
    end else if (tick) begin
      gap    <= (DIV_W+2)'(1);
      gap_ok <= !bus_i.wr;
    end else begin
      gap <= gap + 1'b1;
      if (bus_i.wr) begin
        gap_ok <= 1'b0;
      end
    end
  end

  property p_rate;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (tick && gap_ok) |-> (gap == (DIV_W+2)'({divisor, 1'b0}));
  endproperty
  a_rate: assert property (p_rate) // RQ1
    else $error("tick spacing wrong");

  property p_stop;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (divisor == '0) |=> (bcnt == '0 && !tick);
  endproperty
  a_stop: assert property (p_stop) // RQ2
    else $error("tick with zero divisor");

  property p_start;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (rx_st == ASI_RX_BITS && $past(rx_st) == ASI_RX_IDLE) |->
        ($past(hist) == 3'b111 && !$past(rx_s));
  endproperty
  a_start: assert property (p_start) // RQ5
    else $error("start without three highs");

  property p_rxfull;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (rx_done && !flags[ASI_S_RX_BUFFER_FULL_FLAG]) |=>
        (flags[ASI_S_RX_BUFFER_FULL_FLAG] && rbuf == $past(rsh));
  endproperty
  a_rxfull: assert property (p_rxfull) // RQ24
    else $error("frame not stored");

  property p_tx_buffer_empty_flag;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      tx_load |=> (flags[ASI_S_TX_BUFFER_EMPTY_FLAG] && tx_st == ASI_TX_FRAME && !tsh[0]);
  endproperty
  a_tx_buffer_empty_flag: assert property (p_tx_buffer_empty_flag) // RQ23
    else $error("tx empty not set on load");

  property p_parity;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (rx_done && !flags[ASI_S_RX_BUFFER_FULL_FLAG] && ctrl[ASI_C_PE]) |=>
        (flags[ASI_S_PF] == $past(par_bad));
  endproperty
  a_parity: assert property (p_parity) // RQ11
    else $error("parity flag wrong");

  property p_keep;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (data_rd && flags[ASI_S_RX_BUFFER_FULL_FLAG] && !arm[ASI_S_RX_BUFFER_FULL_FLAG]) |=>
        flags[ASI_S_RX_BUFFER_FULL_FLAG];
  endproperty
  a_keep: assert property (p_keep) // RQ16
    else $error("unarmed flag cleared");

  property p_txkeep;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (data_rd && flags[ASI_S_TX_BUFFER_EMPTY_FLAG] && flags[ASI_S_TC]) |=>
        (flags[ASI_S_TX_BUFFER_EMPTY_FLAG] && flags[ASI_S_TC]);
  endproperty
  a_txkeep: assert property (p_txkeep) // RQ15
    else $error("data read cleared tx flags");

  property p_clear;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      (data_rd && arm[ASI_S_IDLE] && !idle_hit) |=> !flags[ASI_S_IDLE];
  endproperty
  a_clear: assert property (p_clear) // RQ14
    else $error("armed flag not cleared");

  property p_rdata;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      data_rd |=> (rd_data_o == 32'($past(rbuf)));
  endproperty
  a_rdata: assert property (p_rdata) // RQ13
    else $error("data read mismatch");

  property p_pin;
    @(posedge ref_clk_i) disable iff (!resetn_i)
      !pin_cfg[ASI_P_ASSIGN] |=> (txd_oe_o == $past(pin_cfg[ASI_P_GDIR]));
  endproperty
  a_pin: assert property (p_pin) // RQ20
    else $error("gpio lost the tx pin");

  c_rx:   cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                          rx_done && !flags[ASI_S_RX_BUFFER_FULL_FLAG]);
  c_tx:   cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                          tx_end && tx_st == ASI_TX_FRAME);
  c_idle: cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                          idle_hit);
  c_par:  cover property (@(posedge ref_clk_i) disable iff (!resetn_i)
                          set_f[ASI_S_PF]);

endmodule // asi_serial_if

// ### verif/asi_line_partner.sv
/*
  Far-end serial device: sends and takes NRZ frames on the line.
  Assumes the bench ticks clk_i and pulls the released tx wire high.
*/
`timescale 1ns/10ps
module asi_line_partner #(
  parameter int BIT = 32
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      rxd_o
);
  // ====================
  // sending side
  initial rxd_o = 1'b1;
  task automatic send(input logic [10:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd_o <= f[i];
      repeat (BIT) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask

  // ====================
  // taking side
  // samples at mid-bit, so a wrong bit period garbles the frame
  task automatic recv(output logic [10:0] f, input int n, output bit ok);
    int k;
    f = '0;
    ok = 1'b0;
    for (k = 0; k < 4000 && line_i !== 1'b0; k++) @(posedge clk_i);
    if (k < 4000) begin
      ok = 1'b1;
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
        f[i] = line_i;
        repeat (BIT) @(posedge clk_i);
      end
    end
  endtask
endmodule // asi_line_partner

// ### verif/asi_serial_if_bench.sv
/*
  Self-checking bench for the async serial interface.
  Assumes divisor 1 (bit of 32 clocks) and a pull-up on the tx wire.
*/
`timescale 1ns/10ps
module asi_serial_if_bench;
  import asi_pkg::*;
  logic        ref_clk_i;
  logic        resetn_i;
  asi_bus_s    bus_i;
  logic [31:0] rd_data_o;
  logic        rxd;
  logic        txd_o;
  logic        txd_oe_o;
  logic [3:0]  irq_req_o;
  wire         line = txd_oe_o ? txd_o : 1'b1;
  int          fails;
  int          n_checks;
  // {bad parity, parity type, parity enable, long frame}
  logic [3:0]  md [6] = '{4'h0, 4'h2, 4'h6, 4'h1, 4'h7, 4'hB};

  asi_serial_if #(.DIV_W(13)) asi_serial_if_i (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .bus_i     (bus_i),
    .rd_data_o (rd_data_o),
    .rxd_i     (rxd),
    .txd_i     (line),
    .txd_o     (txd_o),
    .txd_oe_o  (txd_oe_o),
    .irq_req_o (irq_req_o)
  );

  asi_line_partner asi_line_partner_i (
    .clk_i  (ref_clk_i),
    .line_i (line),
    .rxd_o  (rxd)
  );

  // ====================
  // helpers
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timeout;
    fails++;
    end_of_test();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk_i);
    bus_i.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_i);
    bus_i <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk_i);
    bus_i.rd <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  function automatic logic [31:0] cw(input logic [3:0] m, input logic te,
                                     input logic re);
    return 32'({m[2:0], te, re});
  endfunction

  // expected line bits, start first, data lsb first, then stop
  function automatic logic [10:0] frame(input logic m, input logic pe,
                                        input logic pt, input logic [8:0] d);
    int          nd;
    logic [10:0] f;
    nd = m ? 9 : 8;
    f = '0;
    for (int i = 0; i < nd; i++) f[i+1] = d[i];
    if (pe) f[nd] = pt ^ (^(d & ((9'h1 << (nd - 1)) - 9'h1)));
    f[nd+1] = 1'b1;
    return f;
  endfunction

  task automatic take(output logic [10:0] f, input int n);
    bit ok;
    asi_line_partner_i.recv(f, n, ok);
    if (!ok) timeout();
  endtask

  // ====================
  // scenarios
  task automatic t_reset;
    rchk(ASI_STAT_OFS, 32'h60);
    rchk(ASI_RATE_OFS, 32'h0);
    rchk(ASI_CTRL_OFS, 32'h0);
    rchk(8'h20, 32'h0);
    wr(ASI_CTRL_OFS, (1 << ASI_C_TIE) | (1 << ASI_C_TX_COMPLETE_IRQ_ENABLE));
    repeat (3) @(posedge ref_clk_i);
    chk(32'(irq_req_o), 32'hC);
    wr(ASI_CTRL_OFS, 1 << ASI_C_TIE);
    repeat (3) @(posedge ref_clk_i);
    chk(32'(irq_req_o), 32'h8);
    rchk(ASI_STAT_OFS, 32'h60);
    wr(ASI_CTRL_OFS, 32'h0);
    $display("reset values done");
  endtask

  task automatic t_pin;
    rchk(ASI_PIN_OFS, 32'h8);
    wr(ASI_PIN_OFS, 32'h4);
    repeat (4) @(posedge ref_clk_i);
    rchk(ASI_PIN_OFS, 32'h4);
    wr(ASI_PIN_OFS, 32'h1);
    repeat (4) @(posedge ref_clk_i);
    chk(32'(line), 32'h1);
    $display("pin sharing done");
  endtask

  task automatic t_stop;
    logic [31:0] s;
    logic [10:0] f;
    int          lows;
    wr(ASI_RATE_OFS, 32'h1);
    wr(ASI_CTRL_OFS, 1 << ASI_C_TE);
    // freeze the preamble: a stopped generator must hold the line high
    wr(ASI_RATE_OFS, 32'h0);
    rd(ASI_STAT_OFS, s);
    wr(ASI_DATA_OFS, 32'h55);
    lows = 0;
    repeat (400) begin
      @(posedge ref_clk_i);
      if (line !== 1'b1) lows++;
    end
    chk(lows, 0);
    wr(ASI_RATE_OFS, 32'h1);
    take(f, 10);
    chk(32'(f), 32'(frame(1'b0, 1'b0, 1'b0, 9'h055)));
    repeat (40) @(posedge ref_clk_i);
    $display("stopped generator done");
  endtask

  task automatic t_tx;
    logic [31:0] s;
    logic [10:0] f;
    foreach (md[i]) begin
      wr(ASI_CTRL_OFS, 32'h0);
      wr(ASI_CTRL_OFS, cw(md[i], 1'b1, 1'b0));
      rd(ASI_STAT_OFS, s);
      wr(ASI_DATA_OFS, 32'h1A5);
      take(f, 10 + md[i][0]);
      chk(32'(f), 32'(frame(md[i][0], md[i][1], md[i][2], 9'h1A5)));
      chk(32'(txd_oe_o), 32'h1);
      repeat (40) @(posedge ref_clk_i);
    end
    rd(ASI_STAT_OFS, s);
    chk(s & 32'h60, 32'h60);
    $display("tx formats done");
  endtask

  task automatic t_rx;
    logic [31:0] s;
    logic [31:0] d;
    logic [31:0] mask;
    int          k;
    foreach (md[i]) begin
      wr(ASI_CTRL_OFS, 32'h0);
      wr(ASI_CTRL_OFS, cw(md[i], 1'b0, 1'b1) | (1 << ASI_C_RIE) |
                       (1 << ASI_C_IDLE_IRQ_ENABLE));
      repeat (400) @(posedge ref_clk_i);
      asi_line_partner_i.send(frame(md[i][0], md[i][1],
        md[i][2] ^ md[i][3], 9'h1A5), 10 + md[i][0]);
      // unarmed data read: rx full must survive it
      rd(ASI_DATA_OFS, d);
      s = '0;
      for (k = 0; k < 40 && s[ASI_S_RX_BUFFER_FULL_FLAG] !== 1'b1; k++)
        rd(ASI_STAT_OFS, s);
      if (k == 40) timeout();
      chk(s & 32'h17, 32'h10 | 32'(md[i][3]));
      chk(32'(irq_req_o[1:0]), 32'h3);
      rd(ASI_DATA_OFS, d);
      mask = (32'h1 << (8 + md[i][0] - md[i][1])) - 32'h1;
      chk(d & mask, 32'h1A5 & mask);
      rd(ASI_STAT_OFS, s);
      chk(s & 32'h77, 32'h60);
    end
    $display("rx formats done");
  endtask

  // ====================
  // run
  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial begin
    resetn_i = 1'b0;
    bus_i = '0;
    fails = 0;
    n_checks = 0;
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_pin();
    t_stop();
    t_tx();
    t_rx();
    end_of_test();
  end
endmodule // asi_serial_if_bench
